// ### adc_serial_sequencer_test.sv
`timescale 1ns/1ps
module adc_serial_sequencer_test;
   import adcss_pkg::*;
   logic             clk = 1'b0;
   logic             rst_n = 1'b0;
   logic             flip = 1'b0;
   logic [RES_W-1:0] conv_res = 12'h000;
   logic [31:0]      lfsr = 32'hAE0E9C0A;
   logic             cs_n, sclk, host_d, host_oe, bit_v, dout_o, dout_oe, din;
   logic             act, win, hld, cnv, bias, rhz, m_s, o_s, b_s;
   logic [10:0]      exp_q[$];
   int               fail_count = 0;
   int               n_compared = 0;
   always #2 clk = ~clk;
   always @(posedge clk) flip <= ~flip;
   // Released wire shows a changing pattern, never the last value
   assign din = dout_oe ? dout_o : (host_oe ? host_d : flip);
   wire   [10:0]     got = {act, dout_oe, dout_o, win, hld, cnv, bias, rhz, m_s, o_s, b_s};
   adcss_host adcss_host_inst (.clk(clk), .cs_n(cs_n), .sclk(sclk), .host_d(host_d), .host_oe(host_oe),
      .bit_v(bit_v));
   adcss_seq adcss_seq_inst (.clk(clk), .rst_n(rst_n), .cs_n(cs_n), .sclk(sclk), .din(din), .dout_o(dout_o),
      .dout_oe(dout_oe), .conv_result(conv_res), .active_o(act), .sample_window(win), .hold_o(hld),
      .converting_o(cnv), .bias_on_o(bias), .ref_hiz_o(rhz), .input_mode_sel(m_s), .odd_sign_sel(o_s),
      .bit_order_sel(b_s));
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Expected pins at the host's capture after fall f past the start bit
   function automatic logic [10:0] expect_at(input int f, input logic [2:0] c, input logic [11:0] r);
      logic d;
      logic on;
      d = (f >= 5 && f <= 16) ? r[16 - f] : ((f >= 17 && f <= 27 && !c[0]) ? r[f - 16] : 1'b0);
      on = (f < 16);
      return {1'b1, f >= 4, d, f == 3, f >= 4, f >= 4 && f < 16, on, ~on, f >= 2 && c[2], f >= 3 && c[1],
         f >= 4 && c[0]};
   endfunction
   task automatic cmp(input logic [10:0] e);
      n_compared++;
      if (got !== e) begin
         fail_count++;
         $display("unexpected at %0t: outputs %h, wanted %h", $time, got, e);
      end
   endtask
   task automatic report_and_stop();
      if (fail_count == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // Deselected: everything off, line released, reference floating
   task automatic idle_check();
      repeat (4) @(posedge clk);
      repeat (60) begin
         @(posedge clk);
         cmp(11'h008);
      end
   endtask
   always @(posedge clk) begin
      if (bit_v === 1'b1) begin
         cmp(exp_q.pop_front());
      end
   end
   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      // Frame 8 is cut mid-conversion; frame 9 shows a clean restart
      for (int c = 0; c < 10; c++) begin
         lfsr = lfsr_next(lfsr);
         @(posedge clk);
         conv_res <= lfsr[11:0];
         for (int j = 0; j < ((c == 8) ? 10 : 32); j++) begin
            exp_q.push_back(expect_at(j - 2, c[2:0], lfsr[11:0]));
         end
         adcss_host_inst.frame(c[2:0], (c == 8) ? 10 : 32);
         fork
            adcss_host_inst.noise(40);
            idle_check();
         join
      end
      report_and_stop();
   end
   // Ten frames take about 5k cycles
   initial begin
      #80000;
      fail_count++;
      report_and_stop();
   end
endmodule

// ### adcss_host.sv
`timescale 1ns/1ps
module adcss_host (
   // Clock
   input  wire logic clk,
   // Link pins
   output logic      cs_n = 1'b1,
   output logic      sclk = 1'b0,
   output logic      host_d = 1'b0,
   output logic      host_oe = 1'b1,
   // Sample strobe
   output logic      bit_v = 1'b0
);
   // One frame: two leading zeros, start, three config bits, then clocks only
   task automatic frame(input logic [2:0] cfg, input int n_clk);
      logic [5:0] word;
      word = {3'b001, cfg};
      cs_n <= 1'b0;
      for (int j = 0; j < n_clk; j++) begin
         sclk    <= 1'b0;
         host_oe <= (j < 6);
         host_d  <= (j < 6) ? word[5 - j] : 1'b0;
         repeat (6) @(posedge clk);
         sclk  <= 1'b1;
         bit_v <= 1'b1;
         @(posedge clk);
         bit_v <= 1'b0;
         repeat (5) @(posedge clk);
      end
      sclk    <= 1'b0;
      host_oe <= 1'b1;
      cs_n    <= 1'b1;
   endtask
   // Pins left toggling while deselected
   task automatic noise(input int n);
      for (int i = 0; i < n; i++) begin
         sclk   <= ~sclk;
         host_d <= host_d ^ ~sclk;
         repeat (3) @(posedge clk);
      end
   endtask
endmodule

// ### adcss_pkg.sv
package adcss_pkg;
   // Widths
   localparam int unsigned RES_W     = 12;
   localparam int unsigned CNT_W     = 5;
   // Falling-edge counts after the start bit
   localparam logic [4:0]  FALL_MODE  = 5'h01;
   localparam logic [4:0]  FALL_ODD   = 5'h02;
   localparam logic [4:0]  FALL_ORDER = 5'h03;
   localparam logic [4:0]  FALL_HOLD  = 5'h04;
   localparam logic [4:0]  CONV_CYC   = 5'h0C;
   localparam logic [4:0]  FALL_END   = 5'h10;
   localparam logic [4:0]  FALL_LSBL  = 5'h1B;
   localparam logic [4:0]  CNT_MAX    = 5'h1F;
   // Reset values
   localparam logic [4:0]  CNT_RST    = 5'h00;
   localparam logic [11:0] RES_RST    = 12'h000;
   typedef enum logic [2:0] {ST_OFF, ST_WAIT_START, ST_CONFIG, ST_CONVERT, ST_SHUTDOWN} adcss_state_t;
endpackage

// ### adcss_seq.sv
`timescale 1ns/1ps
module adcss_seq (
   // Clock and reset
   input  wire logic                         clk,
   input  wire logic                         rst_n,
   // Serial link pins
   input  wire logic                         cs_n,
   input  wire logic                         sclk,
   input  wire logic                         din,
   output logic                              dout_o,
   output logic                              dout_oe,
   // Analog core
   input  wire logic [adcss_pkg::RES_W-1:0]  conv_result,
   output logic                              active_o,
   output logic                              sample_window,
   output logic                              hold_o,
   output logic                              converting_o,
   output logic                              bias_on_o,
   output logic                              ref_hiz_o,
   // Captured configuration
   output logic                              input_mode_sel,
   output logic                              odd_sign_sel,
   output logic                              bit_order_sel
);
   import adcss_pkg::*;

   // Two-flop synchronisers; sclk edges found on the clk side
   logic         cs_m_r, cs_s_r, sclk_m_r, sclk_s_r, sclk_d_r, din_m_r, din_s_r;
   logic [4:0]   fall_cnt_r;
   logic [11:0]  res_r;
   adcss_state_t state_r, state_nxt;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cs_m_r   <= 1'b1;
         cs_s_r   <= 1'b1;
         sclk_m_r <= 1'b0;
         sclk_s_r <= 1'b0;
         sclk_d_r <= 1'b0;
         din_m_r  <= 1'b0;
         din_s_r  <= 1'b0;
      end else begin
         cs_m_r   <= cs_n;
         cs_s_r   <= cs_m_r;
         sclk_m_r <= sclk;
         sclk_s_r <= sclk_m_r;
         sclk_d_r <= sclk_s_r;
         din_m_r  <= din;
         din_s_r  <= din_m_r;
      end
   end

   wire sck_rise = sclk_s_r & ~sclk_d_r;
   wire sck_fall = ~sclk_s_r & sclk_d_r;
   // Chip select high gates every edge off
   wire run      = ~cs_s_r;
   wire rise_run = run & sck_rise;
   wire fall_run = run & sck_fall;
   wire counting = (state_r == ST_CONFIG) | (state_r == ST_CONVERT) | (state_r == ST_SHUTDOWN);
   // Count saturates so zero padding runs on with any number of clocks
   wire cnt_step = fall_run & counting & (fall_cnt_r != CNT_MAX);
   wire [4:0] fall_cnt_nxt = cnt_step ? fall_cnt_r + 5'h01 : fall_cnt_r;
   // Configuration captured on rising edges, one bit per fall count
   wire cap_mode  = rise_run & (state_r == ST_CONFIG) & (fall_cnt_r == FALL_MODE);
   wire cap_odd   = rise_run & (state_r == ST_CONFIG) & (fall_cnt_r == FALL_ODD);
   wire cap_order = rise_run & (state_r == ST_CONFIG) & (fall_cnt_r == FALL_ORDER);
   wire hold_go   = fall_run & (state_r == ST_CONFIG) & (fall_cnt_r == FALL_ORDER);
   wire conv_end  = fall_run & (state_r == ST_CONVERT) & (fall_cnt_r == FALL_END - 5'h01);
   wire start_bit = rise_run & (state_r == ST_WAIT_START) & din_s_r;

   // Output bit for the fall count just reached
   wire [3:0] msb_idx = 4'(FALL_END - fall_cnt_nxt);
   wire [3:0] lsb_idx = 4'(fall_cnt_nxt - FALL_END);
   wire in_msb = (fall_cnt_nxt > FALL_HOLD) & (fall_cnt_nxt <= FALL_END);
   wire in_lsb = ~bit_order_sel & (fall_cnt_nxt > FALL_END) & (fall_cnt_nxt <= FALL_LSBL);
   wire [11:0] res_use = hold_go ? conv_result : res_r;
   wire bit_nxt = in_msb ? res_use[msb_idx] : (in_lsb ? res_use[lsb_idx] : 1'b0);

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_OFF:        if (run) state_nxt = ST_WAIT_START;
         ST_WAIT_START: if (start_bit) state_nxt = ST_CONFIG;
         ST_CONFIG:     if (hold_go) state_nxt = ST_CONVERT;
         ST_CONVERT:    if (conv_end) state_nxt = ST_SHUTDOWN;
         ST_SHUTDOWN:   state_nxt = ST_SHUTDOWN;                   // Later din ignored
         default:       state_nxt = ST_OFF;
      endcase
      if (!run) state_nxt = ST_OFF;
   end

   always_ff @(posedge clk) begin
      if (!rst_n || !run) begin
         state_r        <= ST_OFF;
         fall_cnt_r     <= CNT_RST;
         res_r          <= RES_RST;
         dout_o         <= 1'b0;
         dout_oe        <= 1'b0;
         sample_window  <= 1'b0;
         hold_o         <= 1'b0;
         converting_o   <= 1'b0;
         bias_on_o      <= 1'b0;
         ref_hiz_o      <= 1'b1;
         input_mode_sel <= 1'b0;
         odd_sign_sel   <= 1'b0;
         bit_order_sel  <= 1'b0;
         active_o       <= 1'b0;
      end else begin
         state_r    <= state_nxt;
         fall_cnt_r <= fall_cnt_nxt;
         active_o   <= 1'b1;
         if (state_r == ST_OFF) begin
            bias_on_o <= 1'b1;
            ref_hiz_o <= 1'b0;
         end
         if (cap_mode) input_mode_sel <= din_s_r;
         if (cap_odd) odd_sign_sel <= din_s_r;
         if (cap_odd) sample_window <= 1'b1;
         if (cap_order) bit_order_sel <= din_s_r;
         if (hold_go) begin
            // Result taken at hold; analog core must settle it by then
            res_r         <= conv_result;
            sample_window <= 1'b0;
            hold_o        <= 1'b1;
            converting_o  <= 1'b1;
            dout_oe       <= 1'b1;
         end
         if (conv_end) begin
            converting_o <= 1'b0;
            bias_on_o    <= 1'b0;
            ref_hiz_o    <= 1'b1;
         end
         // Launch on falling edges only; null bit then data
         if (fall_run && (hold_go || state_r == ST_CONVERT || state_r == ST_SHUTDOWN)) dout_o <= bit_nxt;
      end
   end

   // Edge count while sampling, for the window length check only
   logic [1:0]   win_edges_r;

   always_ff @(posedge clk) begin
      if (!rst_n || !sample_window) begin
         win_edges_r <= 2'h0;
      end else if (rise_run || fall_run) begin
         win_edges_r <= win_edges_r + 2'h1;
      end
   end

   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   AST_DRIVE_FOURTH: assert property ($rose(dout_oe) |-> fall_cnt_r == FALL_HOLD && !dout_o)
      else $error("line driven at wrong edge");
   AST_CS_OFF: assert property (cs_s_r |=> !dout_oe && !bias_on_o && ref_hiz_o && !active_o)
      else $error("not shut down with chip select high");
   AST_AUTO_OFF: assert property (conv_end |=> !bias_on_o && ref_hiz_o && !converting_o)
      else $error("no shutdown after conversion");
   AST_STAY_OFF: assert property (run && state_r == ST_SHUTDOWN |=> !bias_on_o || !run)
      else $error("bias came back after conversion");
   AST_IGNORE_PINS: assert property (cs_s_r [*2] |-> state_r == ST_OFF && fall_cnt_r == CNT_RST)
      else $error("activity with chip select high");
   AST_WIN_OPEN: assert property ($rose(sample_window) |-> fall_cnt_r == FALL_ODD)
      else $error("window opened at wrong bit");
   AST_WIN_HOLD: assert property ($fell(sample_window) && run |-> hold_o && converting_o && fall_cnt_r == FALL_HOLD)
      else $error("hold not entered on window close");
   AST_CONV_LEN: assert property ($fell(converting_o) && run |-> fall_cnt_r == FALL_HOLD + CONV_CYC)
      else $error("conversion length wrong");
   AST_LAUNCH_FALL: assert property ($changed(dout_o) && run |-> $past(sck_fall))
      else $error("data launched off falling edge");
   AST_START_BIT: assert property (start_bit |=> state_r == ST_CONFIG || !run)
      else $error("start bit missed");
   AST_ZERO_LEAD: assert property (rise_run && state_r == ST_WAIT_START && !din_s_r |=> state_r != ST_CONFIG)
      else $error("zero taken as start");
   AST_PAD_ZERO: assert property (run && bit_order_sel && state_r == ST_SHUTDOWN && fall_cnt_r > FALL_END |-> !dout_o)
      else $error("no zero padding");
   AST_HIZ_EARLY: assert property (run && state_r != ST_CONVERT && state_r != ST_SHUTDOWN |-> !dout_oe)
      else $error("output enabled early");
   AST_WIN_LEN: assert property ($fell(sample_window) && run |-> win_edges_r == 2'h3)
      else $error("sampling window not three half cycles");
   AST_OE_STAYS: assert property (dout_oe && run |=> dout_oe)
      else $error("line released during frame");
   AST_HOLD_STAYS: assert property (hold_o && run |=> hold_o)
      else $error("hold dropped during frame");
   AST_BIAS_ON: assert property ($rose(active_o) |-> bias_on_o && !ref_hiz_o)
      else $error("core not powered on select");
   AST_CFG_STABLE: assert property (run && hold_o |=> $stable({input_mode_sel, odd_sign_sel, bit_order_sel}))
      else $error("configuration changed after order bit");
   AST_WAIT_CLEAR: assert property (state_r == ST_WAIT_START |-> fall_cnt_r == CNT_RST && !dout_oe)
      else $error("count or line busy before start");
   AST_WAIT_IDLE: assert property (state_r == ST_WAIT_START |-> !sample_window && !hold_o && !converting_o)
      else $error("sampling or hold before configuration");
   AST_CONV_BIAS: assert property (converting_o |-> bias_on_o && !ref_hiz_o)
      else $error("core off while converting");
   AST_SHUT_NO_CONV: assert property (state_r == ST_SHUTDOWN |-> !converting_o && !bias_on_o)
      else $error("core on after conversion");
   AST_ACTIVE_RUN: assert property (state_r != ST_OFF |-> active_o)
      else $error("busy while inactive");
   AST_DOUT_QUIET: assert property (!dout_oe |-> !dout_o)
      else $error("data set while released");

   // Main scenarios

   COV_START: cover property (start_bit);
   COV_CONV: cover property (conv_end);
   COV_LSBF: cover property (run && !bit_order_sel && fall_cnt_r == FALL_LSBL);
   COV_DRIVE: cover property ($rose(dout_oe));
   COV_CUT: cover property (converting_o && cs_s_r);
endmodule
